/* logic/sensor_drive_map.vh */
`ifndef SENSOR_DRIVE_MAP_VH
`define SENSOR_DRIVE_MAP_VH

// ----------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------
`define SDM_CLK_DIV_CH0 8'h14
`define SDM_CLK_DIV_CH1 8'h15
`define SDM_CLK_DIV_CH2 8'h16
`define SDM_CLK_DIV_CH3 8'h17
`define SDM_DRIVE_CH0 8'h1e
`define SDM_DRIVE_CH1 8'h1f
`define SDM_DRIVE_CH2 8'h20
`define SDM_DRIVE_CH3 8'h21

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SDM_FIXED_HI 15
`define SDM_FIXED_LO 11
`define SDM_CAL_HI 10
`define SDM_CAL_LO 6
`define SDM_FREF_HI 9
`define SDM_FREF_LO 0
`define SDM_FIN_HI 15
`define SDM_FIN_LO 12

// ----------------------------------------------------------------
// Reset values and code limits
// ----------------------------------------------------------------
`define SDM_CODE_RST 5'h00
`define SDM_CODE_MAX 5'h1f
`define SDM_CODE_MIN 5'h00
`define SDM_FREF_RST 10'h001
`define SDM_FIN_RST 4'h1

`endif

/* logic/sensor_drive_control.v */
// Summary of operation
// - Every channel except the active one has both pins grounded.
// - Sleep or shutdown leaves no channel active; all pins grounded.
// - Drive only the active channel during conversion, then ground it.
// - Override clear: search drive code on every entry into active mode.
// - Search settles on code giving amplitude between 1.2 and 1.8 V.
// - Chosen code readable in bits 10:6 of channel drive register.
// - Stopped oscillation reports all-zero output samples.
// - Correction on: adjust drive between conversions on active channels.
// - Correction updates calibrated field on each drive change, same code.
// - Channel 0 boost drive only when enabled and scan is off.
// - Each channel has its own reference and sensor divider setting.
// - Fixed code used only with correction off and override set.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_drive_map.vh"

module sensor_drive_control #(
  parameter NUM_CH = 4,
  parameter SAMPLE_W = 12
) (
  // Clock, reset, enable
  input wire i_clk_sys,
  input wire i_nrst,
  input wire i_ce,
  // Register port
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  output reg [15:0] o_reg_rdata_q,
  // Mode controls
  input wire i_sleep,
  input wire i_drive_override,
  input wire i_amplitude_correction_disable,
  input wire i_ch0_boost_drive,
  input wire i_multi_channel_scan,
  // Conversion core
  input wire [1:0] i_active_ch,
  input wire i_conv_busy,
  input wire i_conv_done,
  input wire i_sample_valid,
  input wire [SAMPLE_W-1:0] i_sample_raw,
  // Analog comparators (asynchronous)
  input wire i_amp_low,
  input wire i_amp_high,
  input wire i_osc_alive,
  // Sensor front end
  output reg [NUM_CH-1:0] o_sensor_pin_a_gnd_q,
  output reg [NUM_CH-1:0] o_sensor_pin_b_gnd_q,
  output reg [NUM_CH-1:0] o_drive_en_q,
  output reg [4:0] o_drive_code_q,
  output reg o_boost_drive_q,
  output reg [SAMPLE_W-1:0] o_sample_q,
  output reg o_sample_valid_q
);

  // ----------------------------------------------------------------
  // Saturating step toward the amplitude window
  // ----------------------------------------------------------------
  function [4:0] step_code;
    input [4:0] code;
    input low;
    input high;
    begin
      step_code = code;
      if (low && code != `SDM_CODE_MAX) begin
        step_code = code + 5'h01;
      end else if (high && !low && code != `SDM_CODE_MIN) begin
        step_code = code - 5'h01;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  wire amp_low = sync2_q[0];
  wire amp_high = sync2_q[1];
  wire osc_alive = sync2_q[2];

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else if (i_ce) begin
      sync1_q <= {i_osc_alive, i_amp_high, i_amp_low};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [4:0] fixed_drive_code_q [0:NUM_CH-1];
  reg [4:0] calibrated_drive_code_q [0:NUM_CH-1];
  reg [9:0] fref_div_q [0:NUM_CH-1];
  reg [3:0] fin_div_q [0:NUM_CH-1];
  reg [NUM_CH-1:0] search_done_q;
  reg sleep_q;
  integer k;
  // Separate loop index so the readback logic has its own driver
  integer j;

  wire active = !i_sleep;
  wire wake = sleep_q && !i_sleep;
  wire use_fixed = i_amplitude_correction_disable && i_drive_override;
  wire in_window = !amp_low && !amp_high;
  wire [4:0] cal_now = calibrated_drive_code_q[i_active_ch];
  wire [4:0] cal_next = step_code(cal_now, amp_low, amp_high);
  wire searching = !i_drive_override && !search_done_q[i_active_ch];

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sleep_q <= 1'b1;
      search_done_q <= {NUM_CH{1'b0}};
      for (k = 0; k < NUM_CH; k = k + 1) begin
        fixed_drive_code_q[k] <= `SDM_CODE_RST;
        calibrated_drive_code_q[k] <= `SDM_CODE_RST;
        fref_div_q[k] <= `SDM_FREF_RST;
        fin_div_q[k] <= `SDM_FIN_RST;
      end
    end else if (i_ce) begin
      sleep_q <= i_sleep;
      if (i_reg_wr) begin
        for (k = 0; k < NUM_CH; k = k + 1) begin
          if (i_reg_addr == `SDM_DRIVE_CH0 + k[7:0]) begin
            fixed_drive_code_q[k] <=
              i_reg_wdata[`SDM_FIXED_HI:`SDM_FIXED_LO];
          end
          if (i_reg_addr == `SDM_CLK_DIV_CH0 + k[7:0]) begin
            fref_div_q[k] <= i_reg_wdata[`SDM_FREF_HI:`SDM_FREF_LO];
            fin_div_q[k] <= i_reg_wdata[`SDM_FIN_HI:`SDM_FIN_LO];
          end
        end
      end
      if (wake) begin
        search_done_q <= {NUM_CH{1'b0}};
      end else if (active && i_conv_done) begin
        if (searching) begin
          // stop once amplitude sits in window or the code can step no further
          if (in_window || cal_next == cal_now) begin
            search_done_q[i_active_ch] <= 1'b1;
          end
          calibrated_drive_code_q[i_active_ch] <= cal_next;
        end else if (!i_amplitude_correction_disable) begin
          calibrated_drive_code_q[i_active_ch] <= cal_next;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  reg [15:0] rdata_d;
  always @* begin
    rdata_d = 16'h0000;
    for (j = 0; j < NUM_CH; j = j + 1) begin
      if (i_reg_addr == `SDM_DRIVE_CH0 + j[7:0]) begin
        rdata_d = {fixed_drive_code_q[j], calibrated_drive_code_q[j],
                   6'h00};
      end
      if (i_reg_addr == `SDM_CLK_DIV_CH0 + j[7:0]) begin
        rdata_d = {fin_div_q[j], 2'h0, fref_div_q[j]};
      end
    end
  end

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata_q <= 16'h0000;
    end else if (i_ce && i_reg_rd) begin
      o_reg_rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Sensor switches and drive
  // ----------------------------------------------------------------
  reg [NUM_CH-1:0] drive_d;
  always @* begin
    drive_d = {NUM_CH{1'b0}};
    if (active && i_conv_busy) begin
      drive_d[i_active_ch] = 1'b1;
    end
  end

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sensor_pin_a_gnd_q <= {NUM_CH{1'b1}};
      o_sensor_pin_b_gnd_q <= {NUM_CH{1'b1}};
      o_drive_en_q <= {NUM_CH{1'b0}};
      o_drive_code_q <= `SDM_CODE_RST;
      o_boost_drive_q <= 1'b0;
    end else if (i_ce) begin
      o_sensor_pin_a_gnd_q <= ~drive_d;
      o_sensor_pin_b_gnd_q <= ~drive_d;
      o_drive_en_q <= drive_d;
      if (use_fixed) begin
        o_drive_code_q <= fixed_drive_code_q[i_active_ch];
      end else begin
        o_drive_code_q <= cal_now;
      end
      // channel 0 boost, single channel only
      o_boost_drive_q <= i_ch0_boost_drive && !i_multi_channel_scan &&
                         drive_d[0];
    end
  end

  // ----------------------------------------------------------------
  // Sample output
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sample_q <= {SAMPLE_W{1'b0}};
      o_sample_valid_q <= 1'b0;
    end else if (i_ce) begin
      o_sample_valid_q <= i_sample_valid;
      if (i_sample_valid) begin
        o_sample_q <= osc_alive ? i_sample_raw : {SAMPLE_W{1'b0}};
      end
    end
  end

endmodule

`default_nettype wire

/* verification/coil_model.sv */
`timescale 1ns/1ps
`default_nettype none
module coil_model (
  // Drive from the block, amplitude window of the coil
  input wire logic [4:0] i_drive_code,
  input wire logic [5:0] i_win_lo,
  input wire logic [5:0] i_win_hi,
  // Comparator levels seen by the block
  output logic o_amp_low,
  output logic o_amp_high
);
  assign o_amp_low = {1'b0, i_drive_code} < i_win_lo;
  assign o_amp_high = {1'b0, i_drive_code} > i_win_hi;
endmodule
`default_nettype wire

/* verification/sensor_drive_control_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_drive_checker (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_sleep,
  input wire logic i_ch0_boost_drive,
  input wire logic i_multi_channel_scan,
  input wire logic [1:0] i_active_ch,
  input wire logic i_conv_busy,
  input wire logic i_sample_valid,
  input wire logic [3:0] o_sensor_pin_a_gnd_q,
  input wire logic [3:0] o_sensor_pin_b_gnd_q,
  input wire logic [3:0] o_drive_en_q,
  input wire logic o_boost_drive_q,
  input wire logic o_sample_valid_q
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence drive_req;
    i_ce && !i_sleep && i_conv_busy;
  endsequence
  sequence one_sample;
    i_ce && i_sample_valid ##1 i_ce && !i_sample_valid;
  endsequence
  pin_pair_a: assert property (
    o_sensor_pin_a_gnd_q == o_sensor_pin_b_gnd_q)
    else $error("pin pair differs");
  gnd_inverse_a: assert property (
    o_sensor_pin_a_gnd_q == ~o_drive_en_q)
    else $error("ground not inverse of drive");
  sleep_ground_a: assert property (
    i_ce && i_sleep |=> o_drive_en_q == 4'h0)
    else $error("drive in sleep");
  one_drive_a: assert property ($onehot0(o_drive_en_q))
    else $error("several channels driven");
  active_drive_a: assert property (drive_req |=>
    o_drive_en_q == (4'h1 << $past(i_active_ch)))
    else $error("wrong channel");
  idle_ground_a: assert property (i_ce && !i_conv_busy |=> !o_drive_en_q)
    else $error("drive outside conversion");
  boost_on_a: assert property (drive_req ##0 i_active_ch == 2'h0 &&
    i_ch0_boost_drive && !i_multi_channel_scan |=> o_boost_drive_q)
    else $error("boost missing");
  boost_scan_a: assert property (
    i_ce && i_multi_channel_scan |=> !o_boost_drive_q)
    else $error("boost during scan");
  sample_pulse_a: assert property (one_sample |->
    o_sample_valid_q ##1 !o_sample_valid_q) else $error("sample pulse wrong");
endmodule
bind sensor_drive_control sensor_drive_checker chk_u (.i_clk_sys, .i_nrst,
  .i_ce, .i_sleep, .i_ch0_boost_drive, .i_multi_channel_scan, .i_active_ch,
  .i_conv_busy, .i_sample_valid, .o_sensor_pin_a_gnd_q, .o_sensor_pin_b_gnd_q,
  .o_drive_en_q, .o_boost_drive_q, .o_sample_valid_q);
`default_nettype wire

/* verification/sensor_drive_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_drive_control_bench;
  logic i_clk_sys, i_nrst, i_ce, i_reg_wr, i_reg_rd, i_sleep, i_conv_busy;
  logic i_drive_override, i_amplitude_correction_disable, i_ch0_boost_drive;
  logic i_multi_channel_scan, i_conv_done, i_sample_valid, i_osc_alive;
  logic i_amp_low, i_amp_high, o_boost_drive_q, o_sample_valid_q;
  logic [1:0] i_active_ch;
  logic [7:0] i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata_q;
  logic [11:0] i_sample_raw, o_sample_q;
  logic [3:0] o_sensor_pin_a_gnd_q, o_sensor_pin_b_gnd_q, o_drive_en_q;
  logic [4:0] o_drive_code_q;
  logic [5:0] win_lo, win_hi;
  int err_total, cmp_count, corr, c, cal[4], fix[4];
  sensor_drive_control dut_u (.i_clk_sys, .i_nrst, .i_ce, .i_reg_wr,
    .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata_q, .i_sleep,
    .i_drive_override, .i_amplitude_correction_disable, .i_ch0_boost_drive,
    .i_multi_channel_scan, .i_active_ch, .i_conv_busy, .i_conv_done,
    .i_sample_valid, .i_sample_raw, .i_amp_low, .i_amp_high, .i_osc_alive,
    .o_sensor_pin_a_gnd_q, .o_sensor_pin_b_gnd_q, .o_drive_en_q,
    .o_drive_code_q, .o_boost_drive_q, .o_sample_q, .o_sample_valid_q);
  coil_model coil_u (.i_drive_code(o_drive_code_q), .i_win_lo(win_lo),
    .i_win_hi(win_hi), .o_amp_low(i_amp_low), .o_amp_high(i_amp_high));
  task automatic tick(int n = 1);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_io(logic w, logic [7:0] a, logic [15:0] d);
    i_reg_wr = w;
    i_reg_rd = !w;
    i_reg_addr = a;
    i_reg_wdata = d;
    tick();
    i_reg_wr = 0;
    i_reg_rd = 0;
    tick();
  endtask
  // One conversion; the drive code model steps at its end
  task automatic convert(int ch);
    logic [11:0] raw;
    raw = 12'($urandom);
    i_osc_alive = 1'($urandom);
    i_active_ch = ch[1:0];
    i_conv_busy = 1;
    tick(6);
    check("drive_en", 4'h1 << ch, o_drive_en_q);
    check("boost", i_ch0_boost_drive && !i_multi_channel_scan && ch == 0,
      o_boost_drive_q);
    i_sample_raw = raw;
    i_sample_valid = 1;
    tick();
    check("sample_valid", 16'h1, o_sample_valid_q);
    i_sample_valid = 0;
    i_conv_busy = 0;
    i_conv_done = 1;
    tick();
    i_conv_done = 0;
    check("sample", i_osc_alive ? raw : 12'h0, o_sample_q);
    if (corr && cal[ch] < win_lo) begin
      cal[ch] = (cal[ch] == 31) ? 31 : cal[ch] + 1;
    end else if (corr && cal[ch] > win_hi) begin
      cal[ch] = (cal[ch] == 0) ? 0 : cal[ch] - 1;
    end
    tick(3);
    check("code", (i_drive_override && i_amplitude_correction_disable) ?
      fix[ch] : cal[ch], o_drive_code_q);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    i_clk_sys = 0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    void'($urandom(32'h3bbb5b5f));
    {i_nrst, i_reg_wr, i_reg_rd, i_conv_busy, i_conv_done} = '0;
    {i_sample_valid, i_drive_override, i_multi_channel_scan} = '0;
    {i_ce, i_sleep, i_amplitude_correction_disable, i_ch0_boost_drive} = '1;
    {i_osc_alive, i_active_ch, i_reg_addr, i_reg_wdata, i_sample_raw} = '0;
    {win_lo, win_hi, corr} = {6'd10, 6'd14, 32'd1};
    cal = '{default: 0};
    tick(8);
    i_nrst = 1;
    tick();
    for (c = 0; c < 4; c++) begin
      fix[c] = $urandom_range(31);
      reg_io(1, 8'(8'h1e + c), {fix[c][4:0], 11'h7ff});
      reg_io(0, 8'(8'h1e + c), 16'h0);
      check("drive_reg", {fix[c][4:0], 11'h0}, o_reg_rdata_q);
    end
    reg_io(1, 8'h15, 16'hffff);
    reg_io(0, 8'h15, 16'h0);
    check("divider", 16'hf3ff, o_reg_rdata_q);
    reg_io(0, 8'h30, 16'h0);
    check("unmapped", 16'h0, o_reg_rdata_q);
    // Search on wake, then hold, then correction up to saturation
    i_sleep = 0;
    repeat (12) convert(1);
    {win_lo, win_hi, corr} = {6'd20, 6'd22, 32'd0};
    repeat (3) convert(1);
    {i_amplitude_correction_disable, corr} = {1'b0, 32'd1};
    repeat (12) convert(1);
    win_lo = 6'd40;
    repeat (13) convert(1);
    reg_io(0, 8'h1f, 16'h0);
    check("cal_reg", {fix[1][4:0], 5'd31, 6'h0}, o_reg_rdata_q);
    // Conversion requested while asleep must still leave all pins grounded
    i_sleep = 1;
    i_conv_busy = 1;
    tick(2);
    check("sleep_gnd", 4'hf, o_sensor_pin_a_gnd_q);
    check("sleep_gnd_b", 4'hf, o_sensor_pin_b_gnd_q);
    check("sleep_drive", 4'h0, o_drive_en_q);
    i_conv_busy = 0;
    // Host stores the calibrated code as the fixed one before waking
    fix[1] = 31;
    reg_io(1, 8'h1f, {5'd31, 11'h0});
    {i_sleep, i_drive_override, i_amplitude_correction_disable} = 3'b011;
    corr = 0;
    for (c = 0; c < 8; c++) begin
      i_multi_channel_scan = c >= 4;
      convert(c % 4);
    end
    // Host tunes channel 2 by watching the coil amplitude
    {win_lo, win_hi} = {6'd20, 6'd22};
    convert(2);
    repeat (6) begin
      if (i_amp_low && fix[2] < 31) begin
        fix[2]++;
      end else if (i_amp_high && fix[2] > 0) begin
        fix[2]--;
      end
      reg_io(1, 8'h20, {fix[2][4:0], 11'h0});
      convert(2);
    end
    // Clock enable low freezes writes and drive
    i_ce = 0;
    i_conv_busy = 1;
    reg_io(1, 8'h1e, 16'h0);
    check("ce_drive", 4'h0, o_drive_en_q);
    {i_ce, i_conv_busy} = 2'b10;
    reg_io(0, 8'h1e, 16'h0);
    check("ce_hold", {fix[0][4:0], 11'h0}, o_reg_rdata_q);
    finish_test();
  end
endmodule
`default_nettype wire
